// >>> sp_pkg.sv
/*
  sp_pkg: constants and state types for the serial port block.
  Assumes one core clock equal to the oscillator, twelve phases per machine cycle.
*/
`default_nettype none
package sp_pkg;
  // machine cycle phases, S1P1 = 0 .. S6P2 = 11
  localparam logic [3:0] PH_S1P1 = 4'h0;
  localparam logic [3:0] PH_S3P1 = 4'h4;
  localparam logic [3:0] PH_S5P2 = 4'h9;
  localparam logic [3:0] PH_S6P1 = 4'ha;
  localparam logic [3:0] PH_S6P2 = 4'hb;
  // register port addresses
  localparam logic [3:0] ADDR_SCTL   = 4'h0;
  localparam logic [3:0] ADDR_BUF    = 4'h1;
  localparam logic [3:0] ADDR_PWR    = 4'h2;
  localparam logic [3:0] ADDR_TMODE  = 4'h3;
  localparam logic [3:0] ADDR_T1_REL = 4'h4;
  localparam logic [3:0] ADDR_T2_CTL = 4'h5;
  localparam logic [3:0] ADDR_CAP_LO = 4'h6;
  localparam logic [3:0] ADDR_CAP_HI = 4'h7;
  localparam logic [3:0] ADDR_T2_LO  = 4'h8;
  localparam logic [3:0] ADDR_T2_HI  = 4'h9;
  localparam logic [3:0] ADDR_T1_CNT = 4'ha;
  // serial_control_reg fields
  localparam int unsigned SC_RI  = 0;
  localparam int unsigned SC_TI  = 1;
  localparam int unsigned SC_RB9 = 2;
  localparam int unsigned SC_REN = 4;
  localparam int unsigned SC_MPG = 5;
  localparam int unsigned SC_MLO = 6;
  localparam int unsigned SC_MHI = 7;
  // timer2_control_reg fields
  localparam int unsigned T2_CT   = 1;
  localparam int unsigned T2_RUN  = 2;
  localparam int unsigned T2_EXEN = 3;
  localparam int unsigned T2_TX_CLOCK_SELECT = 4;
  localparam int unsigned T2_RCLK = 5;
  localparam int unsigned T2_EXF  = 6;
  localparam int unsigned T2_TF   = 7;
  // other fields and values
  localparam int unsigned PC_BAUD_DOUBLER = 7;
  localparam int unsigned T1_NHI  = 7;
  localparam int unsigned T1_NLO  = 4;
  localparam logic [3:0] T1_AUTO  = 4'h2;
  localparam logic [1:0] MODE_SHIFT = 2'h0;
  localparam logic [1:0] MODE_FIXED = 2'h2;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] BYTE_MAX = 8'hff;
  localparam logic [15:0] WORD_MAX = 16'hffff;
  localparam logic [7:0] TX_MARK  = 8'h01;
  localparam logic [8:0] RX_ALL1  = 9'h1ff;
  localparam logic [8:0] RX_PRE0  = 9'h1fe;
  localparam logic [3:0] DIV_ZERO = 4'h0;
  localparam logic [3:0] DIV_LAST = 4'hf;
  localparam logic [3:0] SAMP_1   = 4'h7;
  localparam logic [3:0] SAMP_2   = 4'h8;
  localparam logic [3:0] SAMP_3   = 4'h9;
  typedef enum logic [2:0] {
    TX_IDLE  = 3'b000,
    TX_WAIT  = 3'b001,
    TX_START = 3'b011,
    TX_DATA  = 3'b010,
    TX_LAST  = 3'b110
  } tx_state_t;
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_ARM   = 2'b01,
    RX_SHIFT = 2'b11,
    RX_DONE  = 2'b10
  } rx_state_t;
endpackage
`default_nettype wire

// >>> serial_port.sv
/*
  serial_port: serial port with baud sources (fixed divide, timer 1, timer 2
  baud generator), shift-register mode and 10-bit asynchronous mode.
  Assumes pins synchronous to CORE_CLK_I, which is the oscillator clock.
*/
// Summary of operation
// - shift-register mode moves one bit per machine cycle, oscillator over twelve.
// - fixed-rate mode runs at oscillator/64, or /32 with baud_doubler set.
// - timer 1 baud is overflow rate times doubler factor over 32.
// - timer 1 auto-reload ticks per machine cycle, reloads from timer1_reload_byte.
// - either clock select puts timer 2 into baud generation for that direction.
// - timer 2 rollover reloads from capture pair, sets no overflow flag.
// - timer 2 baud is its overflow rate over 16, counting state times.
// - ext input falling edge sets ext_edge_flag, never reloads in baud mode.
// - shift mode passes data on rx line, tx line clocks, LSB first.
// - buffer write loads marker, send begins at the next S6P2.
// - shift clock low S3 to S5; transmit register shifts right at S6P2.
// - after marker reaches bit one, last shift, then done at S1P1.
// - shift receive starts when enabled, flag clear; preload 111111110 at S6P2.
// - receive clock toggles S3P1 and S6P1; shift at S6P2 with S5P2 sample.
// - preloaded zero at top gives last shift, buffer load, done at S1P1.
// - async frame: start zero, eight data LSB first, stop one into ninth bit.
// - async send starts at S1P1 after next divide-by-16 rollover.
// - start bit until next rollover, then data bits, shifting per rollover.
// - marker beside MSB gives last shift, send drops, tx_done_flag sets.
// - sample at sixteen times bit rate; falling edge resets counter, loads 1FF.
// - majority of states 7, 8, 9; nonzero start bit aborts reception.
// - final shift stores only if flag clear and gate allows; then hunt again.
// - async reception only starts while rx_enable_bit is set.
// - service request follows either done flag; software clears both flags.
`timescale 1ns/100ps
`default_nettype none
module serial_port
  import sp_pkg::*;
(
  // clock, reset, enable
  input  wire logic       CORE_CLK_I,
  input  wire logic       NRST_I,
  input  wire logic       CE_I,
  // register port
  input  wire logic [3:0] ADDR_I,
  input  wire logic [7:0] WDATA_I,
  input  wire logic       WR_I,
  input  wire logic       RD_I,
  output logic      [7:0] RDATA_O,
  // serial lines
  input  wire logic       RXD_I,
  output logic            RXD_O,
  output logic            RXD_OE_O,
  output logic            TXD_O,
  // timer 2 pins
  input  wire logic       TIMER2_CNT_I,
  input  wire logic       TIMER2_EXT_I,
  // service request
  output logic            SERIAL_IRQ_O
);
  logic [3:0]  ph_q;
  logic [3:0]  ph_nxt;
  logic        mc_tick;
  logic        st_tick;
  logic        wr;
  logic        wr_buf;
  logic [7:0]  sctl_q;
  logic [7:0]  sctl_d;
  logic [7:0]  pwr_q;
  logic [7:0]  tmode_q;
  logic [7:0]  t1_rel_q;
  logic [7:0]  t1_cnt_q;
  logic [7:0]  t2ctl_q;
  logic [7:0]  t2ctl_d;
  logic [7:0]  cap_lo_q;
  logic [7:0]  cap_hi_q;
  logic [15:0] t2_cnt_q;
  logic [7:0]  rx_buf_q;
  logic [7:0]  rd_val;
  logic [1:0]  mode;
  logic        mode0;
  logic        mode2;
  logic        t1_run;
  logic        t1_ovf;
  logic        t2_inc;
  logic        t2_ovf;
  logic        cnt_pin_q;
  logic        ext_pin_q;
  logic        half_q;
  logic        pre;
  logic        fixed_tick;
  logic        tx_tick;
  logic        rx_tick;
  logic [3:0]  tx_div_q;
  logic [3:0]  rx_div_q;
  logic        tx_roll;
  tx_state_t   tx_st_q;
  logic [8:0]  tx_sr_q;
  logic        tx_go_q;
  logic        tx_mark;
  logic        tx_fin;
  rx_state_t   rx_st_q;
  logic [8:0]  rx_sr_q;
  logic        rx_first_q;
  logic        v1_q;
  logic        v2_q;
  logic        rx0_bit_q;
  logic        rx_prev_q;
  logic        rx_maj;
  logic        rx_edge;
  logic        rx_decide;
  logic        rx_abort;
  logic        rx_ok;
  logic        rx0_last;
  logic        rx_fin;
  logic        sclk;
  logic        txd_d;
  logic        rxd_d;
  logic        rxoe_d;

  assign ph_nxt  = (ph_q == PH_S6P2) ? PH_S1P1 : ph_q + 4'h1;
  assign mc_tick = CE_I && ph_q == PH_S6P2;
  assign st_tick = CE_I && ph_q[0];
  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ph_q <= PH_S1P1;
    end else if (CE_I) begin
      ph_q <= ph_nxt;
    end
  end

  assign wr     = CE_I && WR_I;
  assign wr_buf = wr && ADDR_I == ADDR_BUF;
  assign mode   = sctl_q[SC_MHI:SC_MLO];
  assign mode0  = mode == MODE_SHIFT;
  assign mode2  = mode == MODE_FIXED;

  // plain software registers
  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      pwr_q    <= RST_BYTE;
      tmode_q  <= RST_BYTE;
      t1_rel_q <= RST_BYTE;
      cap_lo_q <= RST_BYTE;
      cap_hi_q <= RST_BYTE;
    end else if (wr) begin
      if (ADDR_I == ADDR_PWR) pwr_q <= WDATA_I;
      if (ADDR_I == ADDR_TMODE) tmode_q <= WDATA_I;
      if (ADDR_I == ADDR_T1_REL) t1_rel_q <= WDATA_I;
      if (ADDR_I == ADDR_CAP_LO) cap_lo_q <= WDATA_I;
      if (ADDR_I == ADDR_CAP_HI) cap_hi_q <= WDATA_I;
    end
  end

  // control flags, hardware set wins over software clear
  always_comb begin
    sctl_d = sctl_q;
    if (wr && ADDR_I == ADDR_SCTL) sctl_d = WDATA_I;
    if (tx_fin) sctl_d[SC_TI] = 1'b1;
    if (rx_fin) sctl_d[SC_RI] = 1'b1;
    if (rx_ok) sctl_d[SC_RB9] = rx_maj;
  end

  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      sctl_q <= RST_BYTE;
    end else if (CE_I) begin
      sctl_q <= sctl_d;
    end
  end

  assign t1_run = tmode_q[T1_NHI:T1_NLO] == T1_AUTO;
  assign t1_ovf = mc_tick && t1_run && t1_cnt_q == BYTE_MAX;
  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      t1_cnt_q <= RST_BYTE;
    end else if (wr && ADDR_I == ADDR_T1_CNT) begin
      t1_cnt_q <= WDATA_I;
    end else if (t1_ovf) begin
      t1_cnt_q <= t1_rel_q;
    end else if (mc_tick && t1_run) begin
      t1_cnt_q <= t1_cnt_q + 8'h01;
    end
  end

  // timer 2 counts state times or pin edges
  assign t2_inc = (t2ctl_q[T2_TX_CLOCK_SELECT] || t2ctl_q[T2_RCLK]) && t2ctl_q[T2_RUN]
                  && (t2ctl_q[T2_CT] ? (CE_I && cnt_pin_q && !TIMER2_CNT_I) : st_tick);
  assign t2_ovf = t2_inc && t2_cnt_q == WORD_MAX;
  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      t2_cnt_q <= {RST_BYTE, RST_BYTE};
    end else if (wr && ADDR_I == ADDR_T2_LO) begin
      t2_cnt_q[7:0] <= WDATA_I;
    end else if (wr && ADDR_I == ADDR_T2_HI) begin
      t2_cnt_q[15:8] <= WDATA_I;
    end else if (t2_ovf) begin
      t2_cnt_q <= {cap_hi_q, cap_lo_q};
    end else if (t2_inc) begin
      t2_cnt_q <= t2_cnt_q + 16'h0001;
    end
  end

  always_comb begin
    t2ctl_d = t2ctl_q;
    if (wr && ADDR_I == ADDR_T2_CTL) t2ctl_d = WDATA_I;
    if (CE_I && t2ctl_q[T2_EXEN] && ext_pin_q && !TIMER2_EXT_I) t2ctl_d[T2_EXF] = 1'b1;
  end

  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      t2ctl_q   <= RST_BYTE;
      cnt_pin_q <= 1'b1;
      ext_pin_q <= 1'b1;
    end else if (CE_I) begin
      t2ctl_q   <= t2ctl_d;
      cnt_pin_q <= TIMER2_CNT_I;
      ext_pin_q <= TIMER2_EXT_I;
    end
  end

  // fixed rate from state times, halved unless doubled
  assign pre        = mode2 ? st_tick : t1_ovf;
  assign fixed_tick = pre && (pwr_q[PC_BAUD_DOUBLER] || half_q);
  assign tx_tick = (!mode2 && t2ctl_q[T2_TX_CLOCK_SELECT]) ? t2_ovf : fixed_tick;
  assign rx_tick = (!mode2 && t2ctl_q[T2_RCLK]) ? t2_ovf : fixed_tick;
  assign tx_roll = tx_tick && tx_div_q == DIV_LAST;

  // halve prescale tick unless doubled, then divide by 16
  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      half_q   <= 1'b0;
      tx_div_q <= DIV_ZERO;
    end else begin
      if (pre) half_q <= !half_q;
      if (tx_tick) tx_div_q <= tx_div_q + 4'h1;
    end
  end

  // receive counter realigned on start edge
  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rx_div_q <= DIV_ZERO;
    end else if (rx_edge) begin
      rx_div_q <= DIV_ZERO;
    end else if (rx_tick) begin
      rx_div_q <= rx_div_q + 4'h1;
    end
  end

  // transmit control
  assign tx_mark = tx_sr_q[8:1] == TX_MARK;
  assign tx_fin  = CE_I && (mode0 ? (tx_st_q == TX_LAST && ph_q == PH_S1P1)
                                  : (tx_st_q == TX_DATA && tx_roll && tx_mark));
  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      tx_st_q <= TX_IDLE;
      tx_sr_q <= {1'b0, RST_BYTE};
      tx_go_q <= 1'b0;
    end else if (CE_I) begin
      if (wr_buf) begin
        tx_sr_q <= {1'b1, WDATA_I};
        tx_st_q <= TX_WAIT;
        tx_go_q <= 1'b0;
      end else begin
        case (tx_st_q)
          TX_WAIT: begin
            if (mode0) begin
              if (mc_tick) tx_st_q <= TX_DATA;
            end else begin
              if (tx_roll) tx_go_q <= 1'b1;
              if (tx_go_q && ph_q == PH_S1P1) begin
                tx_st_q <= TX_START;
                tx_go_q <= 1'b0;
              end
            end
          end
          TX_START: if (tx_roll) tx_st_q <= TX_DATA;
          TX_DATA: begin
            if (mode0 ? mc_tick : tx_roll) begin
              tx_sr_q <= {1'b0, tx_sr_q[8:1]};
              if (tx_mark) tx_st_q <= mode0 ? TX_LAST : TX_IDLE;
            end
          end
          TX_LAST: if (ph_q == PH_S1P1) tx_st_q <= TX_IDLE;
          default: tx_st_q <= TX_IDLE;
        endcase
      end
    end
  end

  // receive decisions
  // two of three samples
  assign rx_maj    = (v1_q && v2_q) || (v1_q && RXD_I) || (v2_q && RXD_I);
  assign rx_edge   = rx_tick && !mode0 && rx_st_q == RX_IDLE && sctl_q[SC_REN]
                     && rx_prev_q && !RXD_I;
  assign rx_decide = rx_tick && !mode0 && rx_st_q == RX_SHIFT && rx_div_q == SAMP_3;
  assign rx_abort  = rx_first_q && rx_maj;
  assign rx_ok     = rx_decide && !rx_abort && !rx_sr_q[0] && !sctl_q[SC_RI]
                     && (!sctl_q[SC_MPG] || rx_maj);
  assign rx0_last  = mc_tick && mode0 && rx_st_q == RX_SHIFT && !rx_sr_q[7];
  assign rx_fin    = rx_ok || (CE_I && mode0 && rx_st_q == RX_DONE && ph_q == PH_S1P1);

  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rx_st_q    <= RX_IDLE;
      rx_sr_q    <= RX_ALL1;
      rx_first_q <= 1'b0;
      v1_q       <= 1'b0;
      v2_q       <= 1'b0;
      rx0_bit_q  <= 1'b0;
      rx_prev_q  <= 1'b1;
      rx_buf_q   <= RST_BYTE;
    end else if (CE_I) begin
      if (rx_tick) rx_prev_q <= RXD_I;
      if (ph_q == PH_S5P2) rx0_bit_q <= RXD_I;
      if (rx_tick && rx_div_q == SAMP_1) v1_q <= RXD_I;
      if (rx_tick && rx_div_q == SAMP_2) v2_q <= RXD_I;
      // last shift, first bit to lsb
      if (rx0_last) rx_buf_q <= {<<{rx_sr_q[6:0], rx0_bit_q}};
      if (rx_ok) rx_buf_q <= rx_sr_q[8:1];
      case (rx_st_q)
        RX_IDLE: begin
          if (mode0) begin
            if (mc_tick && sctl_q[SC_REN] && !sctl_q[SC_RI]) rx_st_q <= RX_ARM;
          end else if (rx_edge) begin
            rx_st_q    <= RX_SHIFT;
            rx_sr_q    <= RX_ALL1;
            rx_first_q <= 1'b1;
          end
        end
        RX_ARM: begin
          if (mc_tick) begin
            rx_sr_q <= RX_PRE0;
            rx_st_q <= RX_SHIFT;
          end
        end
        RX_SHIFT: begin
          if (mode0) begin
            if (mc_tick) begin
              rx_sr_q <= {rx_sr_q[7:0], rx0_bit_q};
              if (!rx_sr_q[7]) rx_st_q <= RX_DONE;
            end
          end else if (rx_decide) begin
            rx_first_q <= 1'b0;
            // resume hunting after frame or abort
            if (rx_abort || !rx_sr_q[0]) begin
              rx_st_q <= RX_IDLE;
            end else begin
              rx_sr_q <= {rx_maj, rx_sr_q[8:1]};
            end
          end
        end
        RX_DONE: if (ph_q == PH_S1P1) rx_st_q <= RX_IDLE;
        default: rx_st_q <= RX_IDLE;
      endcase
    end
  end

  // line drive
  assign sclk = !(ph_nxt >= PH_S3P1 && ph_nxt < PH_S6P1);
  always_comb begin
    txd_d  = 1'b1;
    rxd_d  = 1'b1;
    rxoe_d = 1'b0;
    if (mode0) begin
      // tx line carries the shift clock
      if (tx_st_q == TX_DATA || tx_st_q == TX_LAST || rx_st_q == RX_SHIFT) txd_d = sclk;
      if (tx_st_q == TX_DATA || tx_st_q == TX_LAST) begin
        rxd_d  = tx_sr_q[0];
        rxoe_d = 1'b1;
      end
    end else if (tx_st_q == TX_START) begin
      txd_d = 1'b0;
    end else if (tx_st_q == TX_DATA) begin
      txd_d = tx_sr_q[0];
    end
  end

  // register read mux
  always_comb begin
    case (ADDR_I)
      ADDR_SCTL:   rd_val = sctl_q;
      ADDR_BUF:    rd_val = rx_buf_q;
      ADDR_PWR:    rd_val = pwr_q;
      ADDR_TMODE:  rd_val = tmode_q;
      ADDR_T1_REL: rd_val = t1_rel_q;
      ADDR_T2_CTL: rd_val = t2ctl_q;
      ADDR_CAP_LO: rd_val = cap_lo_q;
      ADDR_CAP_HI: rd_val = cap_hi_q;
      ADDR_T2_LO:  rd_val = t2_cnt_q[7:0];
      ADDR_T2_HI:  rd_val = t2_cnt_q[15:8];
      ADDR_T1_CNT: rd_val = t1_cnt_q;
      default:     rd_val = RST_BYTE;
    endcase
  end

  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      RDATA_O      <= RST_BYTE;
      TXD_O        <= 1'b1;
      RXD_O        <= 1'b1;
      RXD_OE_O     <= 1'b0;
      SERIAL_IRQ_O <= 1'b0;
    end else if (CE_I) begin
      RDATA_O      <= RD_I ? rd_val : RST_BYTE;
      TXD_O        <= txd_d;
      RXD_O        <= rxd_d;
      RXD_OE_O     <= rxoe_d;
      SERIAL_IRQ_O <= sctl_q[SC_RI] || sctl_q[SC_TI];
    end
  end

  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!NRST_I);

  sequence s_tx_last;
    CE_I && mode0 && tx_st_q == TX_LAST && ph_q == PH_S1P1 && !wr_buf;
  endsequence
  sequence s_rx_arm;
    mode0 && rx_st_q == RX_ARM && mc_tick;
  endsequence
  sequence s_rx_loaded;
    rx_st_q == RX_SHIFT && rx_sr_q == RX_PRE0;
  endsequence

  a_mc_wrap: assert property (mc_tick |=> ph_q == PH_S1P1)
    else $error("machine cycle did not wrap");
  a_shift_cycle: assert property ((CE_I && mode0 && tx_st_q == TX_DATA && !mc_tick && !wr_buf)
    |=> $stable(tx_sr_q))
    else $error("shift outside S6P2");
  a_fixed_div: assert property ((mode2 && !pwr_q[PC_BAUD_DOUBLER] && tx_tick) |-> (half_q && ph_q[0]))
    else $error("fixed rate not halved");
  a_t1_source: assert property ((!mode2 && !t2ctl_q[T2_TX_CLOCK_SELECT] && tx_tick) |-> t1_ovf)
    else $error("tick without timer 1 overflow");
  a_t1_reload: assert property ((t1_ovf && !wr) |=> t1_cnt_q == $past(t1_rel_q))
    else $error("timer 1 reload wrong");
  a_t2_reload: assert property ((t2_ovf && !wr)
    |=> t2_cnt_q == {$past(cap_hi_q), $past(cap_lo_q)} && !$rose(t2ctl_q[T2_TF]))
    else $error("timer 2 reload wrong");
  a_ext_edge: assert property ((CE_I && t2ctl_q[T2_EXEN] && ext_pin_q && !TIMER2_EXT_I
    && !t2_inc && !wr) |=> t2ctl_q[T2_EXF] && $stable(t2_cnt_q))
    else $error("ext edge mishandled");
  a_tx_end: assert property (s_tx_last |=> tx_st_q == TX_IDLE && sctl_q[SC_TI])
    else $error("shift transmit end wrong");
  a_rx_preload: assert property (s_rx_arm |=> s_rx_loaded)
    else $error("receive preload wrong");
  a_rx_hunt: assert property (rx_edge
    |=> rx_div_q == DIV_ZERO && rx_sr_q == RX_ALL1 && rx_st_q == RX_SHIFT)
    else $error("start edge not taken");
  a_rx_abort: assert property ((rx_decide && rx_abort) |=> rx_st_q == RX_IDLE)
    else $error("false start not rejected");
  a_irq_flags: assert property ((CE_I && (sctl_q[SC_RI] || sctl_q[SC_TI])) |=> SERIAL_IRQ_O)
    else $error("request missing");
endmodule
`default_nettype wire

// >>> sp_peer.sv
/*
  sp_peer: far side of the serial port, a shift-register device and an async peer.
  Assumes lines sampled on the core clock; the receive line has a pull-up.
*/
`timescale 1ns/100ps
`default_nettype none
module sp_peer (
  // clock
  input  wire logic clk_i,
  // lines from the port
  input  wire logic txd_i,
  input  wire logic dat_i,
  input  wire logic oe_i,
  // line to the port
  output logic      rxd_o
);
  logic       prev_q;
  logic [7:0] cap_q;
  logic [7:0] src_q;
  int         cap_n;
  int         src_n;
  int         cyc;
  int         per;
  initial begin
    rxd_o = 1'b1;
    prev_q = 1'b1;
    cap_n = 0;
    src_n = 8;
    cyc = 0;
    per = 0;
  end
  always @(posedge clk_i) begin
    cyc = cyc + 1;
    prev_q <= txd_i;
    if (txd_i && !prev_q) begin
      per = cyc;
      cyc = 0;
      if (oe_i && cap_n < 8) begin
        cap_q = {dat_i, cap_q[7:1]};
        cap_n++;
      end
      if (src_n < 8) begin
        src_n++;
        src_q = src_q >> 1;
        rxd_o <= (src_n < 8) ? src_q[0] : 1'b1;
      end
    end
  end
  task load_shift(input logic [7:0] v);
    src_q = v;
    src_n = 0;
    rxd_o <= v[0];
  endtask
  // start, eight data lsb first, stop
  task send_frame(input int bt, input logic [7:0] v, input logic stop);
    logic [9:0] f;
    f = {stop, v, 1'b0};
    for (int k = 0; k < 10; k++) begin
      rxd_o <= f[k];
      repeat (bt) @(posedge clk_i);
    end
    rxd_o <= 1'b1;
  endtask
  task rx_frame(input int bt, output logic [7:0] v, output int low, output logic stop);
    int t;
    t = 0;
    low = 0;
    while (txd_i !== 1'b0 && t < 8000) begin
      @(posedge clk_i);
      t++;
    end
    while (txd_i === 1'b0 && low < 8000) begin
      @(posedge clk_i);
      low++;
    end
    repeat (bt / 2) @(posedge clk_i);
    for (int k = 0; k < 8; k++) begin
      v[k] = txd_i;
      repeat (bt) @(posedge clk_i);
    end
    stop = txd_i;
  endtask
endmodule
`default_nettype wire

// >>> test_serial_port.sv
/*
  test_serial_port: register-level tests of the serial port against sp_peer.
  Assumes a 50 MHz core clock and the register map of sp_pkg.
*/
`timescale 1ns/100ps
`default_nettype none
module test_serial_port;
  import sp_pkg::*;
  logic       clk;
  logic       nrst;
  logic       wr;
  logic       rd;
  logic       t2ext;
  logic       rxd_w;
  logic       peer_rxd;
  logic       rxo;
  logic       rxoe;
  logic       txd;
  logic       irq;
  logic       stop;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [7:0] d;
  int         error_cnt;
  int         cmp_count;
  int         low;
  int         i;
  serial_port serial_port_i (.CORE_CLK_I(clk), .NRST_I(nrst), .CE_I(1'b1), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .RXD_I(rxd_w), .RXD_O(rxo),
    .RXD_OE_O(rxoe), .TXD_O(txd), .TIMER2_CNT_I(1'b1), .TIMER2_EXT_I(t2ext),
    .SERIAL_IRQ_O(irq));
  sp_peer sp_peer_i (.clk_i(clk), .txd_i(txd), .dat_i(rxo), .oe_i(rxoe), .rxd_o(peer_rxd));
  assign rxd_w = rxoe ? rxo : peer_rxd;
  always #10 clk = ~clk;
  task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_chk(input string nm, input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(nm, 16'(rdata), 16'(exp));
  endtask
  task tx_async(input int bt, input logic [7:0] v);
    wr_reg(ADDR_BUF, v);
    sp_peer_i.rx_frame(bt, d, low, stop);
    // start bit cut by wait for S1P1 after rollover
    chk("bit time", 16'(low > bt - 12 && low < bt), 16'h0001);
    chk("tx data", 16'(d), 16'(v));
    chk("stop bit", 16'(stop), 16'h0001);
  endtask
  task close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    close_out();
  end
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    t2ext = 1'b1;
    addr = 4'h0;
    wdata = 8'h00;
    error_cnt = 0;
    cmp_count = 0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    chk("idle pins", 16'({txd, rxoe, irq}), 16'h0004);
    rd_chk("doubler reset", ADDR_PWR, 8'h00);
    rd_chk("unmapped", 4'hb, 8'h00);
    wr_reg(ADDR_SCTL, 8'h00);
    wr_reg(ADDR_BUF, 8'h4b);
    for (i = 0; i < 400 && sp_peer_i.cap_n < 8; i++) @(posedge clk);
    chk("shift tx wait", 16'(i < 400), 16'h0001);
    repeat (24) @(posedge clk);
    chk("shift byte", 16'(sp_peer_i.cap_q), 16'h004b);
    chk("shift period", 16'(sp_peer_i.per), 16'd12);
    rd_chk("shift tx done", ADDR_SCTL, 8'h02);
    chk("irq set", 16'(irq), 16'h0001);
    wr_reg(ADDR_SCTL, 8'h00);
    repeat (3) @(posedge clk);
    chk("irq clear", 16'(irq), 16'h0000);
    sp_peer_i.load_shift(8'h35);
    wr_reg(ADDR_SCTL, 8'h10);
    for (i = 0; i < 400 && irq !== 1'b1; i++) @(posedge clk);
    chk("shift rx wait", 16'(i < 400), 16'h0001);
    rd_chk("shift rx done", ADDR_SCTL, 8'h11);
    rd_chk("shift rx byte", ADDR_BUF, 8'h35);
    wr_reg(ADDR_SCTL, 8'h80);
    tx_async(64, 8'ha5);
    rd_chk("fixed tx done", ADDR_SCTL, 8'h82);
    wr_reg(ADDR_PWR, 8'h80);
    tx_async(32, 8'h81);
    wr_reg(ADDR_TMODE, 8'h20);
    wr_reg(ADDR_T1_REL, 8'hff);
    wr_reg(ADDR_SCTL, 8'h40);
    tx_async(192, 8'h69);
    wr_reg(ADDR_SCTL, 8'h50);
    sp_peer_i.send_frame(192, 8'hc3, 1'b1);
    rd_chk("async rx flags", ADDR_SCTL, 8'h55);
    rd_chk("async rx byte", ADDR_BUF, 8'hc3);
    wr_reg(ADDR_SCTL, 8'h50);
    sp_peer_i.send_frame(48, 8'hff, 1'b1);
    repeat (300) @(posedge clk);
    rd_chk("false start", ADDR_SCTL, 8'h50);
    wr_reg(ADDR_SCTL, 8'h70);
    sp_peer_i.send_frame(192, 8'h0f, 1'b0);
    repeat (200) @(posedge clk);
    rd_chk("gate drop", ADDR_SCTL, 8'h70);
    wr_reg(ADDR_SCTL, 8'h51);
    sp_peer_i.send_frame(192, 8'h77, 1'b1);
    rd_chk("flag busy drop", ADDR_BUF, 8'hc3);
    wr_reg(ADDR_SCTL, 8'h40);
    sp_peer_i.send_frame(192, 8'h77, 1'b1);
    rd_chk("rx disabled", ADDR_SCTL, 8'h40);
    wr_reg(ADDR_CAP_LO, 8'hfe);
    wr_reg(ADDR_CAP_HI, 8'hff);
    wr_reg(ADDR_T2_LO, 8'hfe);
    wr_reg(ADDR_T2_HI, 8'hff);
    wr_reg(ADDR_SCTL, 8'h50);
    wr_reg(ADDR_T2_CTL, 8'h14);
    tx_async(64, 8'h3b);
    sp_peer_i.send_frame(192, 8'h96, 1'b1);
    rd_chk("split rates", ADDR_SCTL, 8'h57);
    rd_chk("split rx byte", ADDR_BUF, 8'h96);
    wr_reg(ADDR_T2_CTL, 8'h1c);
    t2ext <= 1'b0;
    repeat (4) @(posedge clk);
    rd_chk("ext edge flag", ADDR_T2_CTL, 8'h5c);
    close_out();
  end
endmodule
`default_nettype wire
